// ===== hdl/hpx_map.svh
// Contract
// - SMBus master and slave are separate, independent buses, never shared.
// - Master does no arbitration; system keeps other masters off its bus.
// - Hot-plug signals of all downstream ports travel via an external I/O expander.
// - After configuration, any hot-plug output change writes all outputs to the expander.
// - On the expander interrupt the device reads all hot-plug inputs.
// - 54 general-purpose pins, direction set per pin by software.
// - Alternate functions enabled by software, slave-bus writes or EEPROM values.
// - Signals with trailing N are active low; all others active high. The code's rst_b_i is also active low, without a trailing N.
// - Slave address bit 5 from strap, bits 6,7 one; EEPROM bits 7:5 = 101.
// - Both strap groups are latched when fundamental reset is released.
// - Slave bits 3:1 from straps, bit 4 zero; EEPROM bits 4:1 from straps.
// - Master loads defaults from EEPROM after reset and carries hot-plug traffic.
`ifndef HPX_MAP_SVH
`define HPX_MAP_SVH
`define HPX_GPIO_NUM 54
`define HPX_IRQ_PIN 8
`define HPX_SLV_HI 2'h3
`define HPX_SLV_B4 1'h0
`define HPX_EE_HI 3'h5
`define HPX_EE_BYTES 4'h8
`define HPX_MAX_BYTES 8
`define HPX_EXP_ADDR 7'h20
`define HPX_RD 1'h1
`define HPX_WR 1'h0
`define HPX_Q_SET 2'h0
`define HPX_Q_RISE 2'h1
`define HPX_Q_SAMPLE 2'h2
`define HPX_Q_FALL 2'h3
`define HPX_ACK_BIT 4'h8
`endif

// ===== hdl/hpx_pkg.sv
package hpx_pkg;
    typedef enum logic [1:0]
    {
        HPX_T_BOOT = 2'h0,
        HPX_T_EE = 2'h1,
        HPX_T_IDLE = 2'h3,
        HPX_T_BUSY = 2'h2
    } hpx_top_e;
    typedef enum logic [1:0]
    {
        HPX_E_IDLE = 2'h0,
        HPX_E_START = 2'h1,
        HPX_E_BITS = 2'h3,
        HPX_E_STOP = 2'h2
    } hpx_eng_e;
endpackage

// ===== hdl/hpx_smb_engine.sv
`timescale 1ns/10ps
`include "hpx_map.svh"
module hpx_smb_engine
(
    input wire logic link_clk_i,
    input wire logic rst_b_i,
    input wire logic req_tgl_i,
    input wire logic [6:0] addr_i,
    input wire logic rd_i,
    input wire logic [3:0] len_i,
    input wire logic [63:0] wdata_i,
    output logic ack_tgl_o,
    output logic [63:0] rdata_o,
    output logic nack_o,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    hpx_pkg::hpx_eng_e st_ff;
    logic req_m_ff, req_s_ff, sda_m_ff, sda_s_ff;
    logic [1:0] q_ff;
    logic [3:0] bit_ff, byte_ff;
    logic [7:0] sh_ff;
    logic scl_ff, sda_ff;
    wire logic start_w = (req_s_ff != ack_tgl_o);
    wire logic rx_byte_w = rd_i && (byte_ff != 4'h0);
    wire logic last_w = (byte_ff == len_i);
    wire logic [2:0] widx_w = 3'(byte_ff);
    wire logic [7:0] wbyte_w = wdata_i[8*widx_w +: 8];
    wire logic data_bit_w = (bit_ff != `HPX_ACK_BIT);
    wire logic nack_w = !rx_byte_w && sda_s_ff;

    // Open drain: drive low only, release for high
    assign scl_oe_o = ~scl_ff;
    assign sda_oe_o = ~sda_ff;

    always_ff @(posedge link_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            req_m_ff <= 1'h0;
            req_s_ff <= 1'h0;
            sda_m_ff <= 1'h1;
            sda_s_ff <= 1'h1;
        end
        else
        begin
            req_m_ff <= req_tgl_i;
            req_s_ff <= req_m_ff;
            sda_m_ff <= sda_i;
            sda_s_ff <= sda_m_ff;
        end
    end

    // Sole master on its own bus: no arbitration, no clock stretching check
    always_ff @(posedge link_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ff <= hpx_pkg::HPX_E_IDLE;
            q_ff <= 2'h0;
            bit_ff <= 4'h0;
            byte_ff <= 4'h0;
            sh_ff <= 8'h0;
            scl_ff <= 1'h1;
            sda_ff <= 1'h1;
            ack_tgl_o <= 1'h0;
            rdata_o <= 64'h0;
            nack_o <= 1'h0;
        end
        else
        begin
            q_ff <= (st_ff == hpx_pkg::HPX_E_IDLE) ? 2'h0 : q_ff + 2'h1;
            case (st_ff)
                hpx_pkg::HPX_E_IDLE:
                begin
                    if (start_w)
                    begin
                        st_ff <= hpx_pkg::HPX_E_START;
                        nack_o <= 1'h0;
                        rdata_o <= 64'h0;
                    end
                end
                hpx_pkg::HPX_E_START:
                begin
                    if (q_ff == `HPX_Q_RISE)
                        sda_ff <= 1'h0;
                    if (q_ff == `HPX_Q_SAMPLE)
                        scl_ff <= 1'h0;
                    if (q_ff == `HPX_Q_FALL)
                    begin
                        st_ff <= hpx_pkg::HPX_E_BITS;
                        sh_ff <= {addr_i, rd_i};
                        bit_ff <= 4'h0;
                        byte_ff <= 4'h0;
                    end
                end
                hpx_pkg::HPX_E_BITS:
                begin
                    case (q_ff)
                        `HPX_Q_SET:
                        begin
                            if (data_bit_w)
                                sda_ff <= rx_byte_w ? 1'h1 : sh_ff[7];
                            else
                                sda_ff <= rx_byte_w ? last_w : 1'h1;
                        end
                        `HPX_Q_RISE:
                            scl_ff <= 1'h1;
                        `HPX_Q_SAMPLE:
                            scl_ff <= 1'h1;
                        default:
                        begin
                            // Synchroniser shows SDA as it stood at the clock rise
                            scl_ff <= 1'h0;
                            bit_ff <= data_bit_w ? bit_ff + 4'h1 : 4'h0;
                            if (data_bit_w)
                                sh_ff <= {sh_ff[6:0], sda_s_ff};
                            else
                            begin
                                if (rx_byte_w)
                                    rdata_o <= {rdata_o[55:0], sh_ff};
                                if (nack_w)
                                    nack_o <= 1'h1;
                                byte_ff <= byte_ff + 4'h1;
                                sh_ff <= wbyte_w;
                                if (last_w || nack_w)
                                    st_ff <= hpx_pkg::HPX_E_STOP;
                            end
                        end
                    endcase
                end
                default:
                begin
                    if (q_ff == `HPX_Q_SET)
                        sda_ff <= 1'h0;
                    if (q_ff == `HPX_Q_RISE)
                        scl_ff <= 1'h1;
                    if (q_ff == `HPX_Q_SAMPLE)
                        sda_ff <= 1'h1;
                    if (q_ff == `HPX_Q_FALL)
                    begin
                        st_ff <= hpx_pkg::HPX_E_IDLE;
                        ack_tgl_o <= ~ack_tgl_o;
                    end
                end
            endcase
        end
    end
endmodule

// ===== hdl/hpx_top.sv
`timescale 1ns/10ps
`include "hpx_map.svh"
module hpx_top
#(
    parameter int HP_OUT_BYTES = 2,
    parameter int HP_IN_BYTES = 2,
    parameter logic [6:0] EXP_ADDR = `HPX_EXP_ADDR
)
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic smb_link_clk_i,
    input wire logic fundamental_reset_n_i,
    input wire logic [3:0] slave_addr_strap_i,
    input wire logic [3:0] master_eeprom_addr_strap_i,
    output logic [6:0] slave_addr_o,
    output logic [6:0] eeprom_addr_o,
    output logic cfg_done_o,
    output logic [63:0] cfg_default_o,
    input wire logic [8*HP_OUT_BYTES-1:0] hp_out_i,
    output logic [8*HP_IN_BYTES-1:0] hp_in_o,
    output logic hp_nack_o,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_dir_i,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_out_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_en_sw_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_en_slave_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_out_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_oe_i,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_pin_i,
    output logic [`HPX_GPIO_NUM-1:0] gpio_pin_o,
    output logic [`HPX_GPIO_NUM-1:0] gpio_pin_oe_o,
    output logic [`HPX_GPIO_NUM-1:0] gpio_in_o,
    input wire logic msmb_sda_i,
    output logic msmb_scl_o,
    output logic msmb_scl_oe_o,
    output logic msmb_sda_o,
    output logic msmb_sda_oe_o
);
    // Byte counts beyond the 64-bit engine buffers are refused
    if (HP_OUT_BYTES < 1 || HP_OUT_BYTES > `HPX_MAX_BYTES)
    begin : g_bad_out
        $error("HP_OUT_BYTES out of range");
    end
    if (HP_IN_BYTES < 1 || HP_IN_BYTES > `HPX_MAX_BYTES)
    begin : g_bad_in
        $error("HP_IN_BYTES out of range");
    end

    localparam int OW = 8 * HP_OUT_BYTES;
    localparam int IW = 8 * HP_IN_BYTES;

    hpx_pkg::hpx_top_e st_ff;
    logic fr_m_ff, fr_s_ff, fr_d_ff;
    logic [7:0] strap_m_ff, strap_s_ff;
    logic [`HPX_GPIO_NUM-1:0] pin_m_ff, pin_s_ff;
    logic ack_m_ff, ack_s_ff, ack_d_ff;
    logic req_tgl_ff, rd_ff;
    logic [6:0] addr_ff;
    logic [3:0] len_ff;
    logic [63:0] wdata_ff;
    logic [OW-1:0] sent_ff;
    logic [`HPX_GPIO_NUM-1:0] oe_ff, out_ff;
    logic ack_tgl_w, eng_nack_w;
    logic [63:0] rdata_w;

    // Master bus pins belong to this block only; slave bus lives elsewhere
    assign msmb_scl_o = 1'h0;
    assign msmb_sda_o = 1'h0;

    wire logic fr_rise_w = fr_s_ff && !fr_d_ff;
    wire logic done_w = ack_s_ff != ack_d_ff;
    wire logic [`HPX_GPIO_NUM-1:0] alt_en_w = alt_en_sw_i | alt_en_slave_i
        | cfg_default_o[`HPX_GPIO_NUM-1:0];
    wire logic irq_en_w = alt_en_w[`HPX_IRQ_PIN];
    wire logic irq_req_w = irq_en_w && !pin_s_ff[`HPX_IRQ_PIN];
    wire logic out_dirty_w = (hp_out_i != sent_ff);
    wire logic [63:0] hp_wdata_w = 64'(hp_out_i);

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fr_m_ff <= 1'h0;
            fr_s_ff <= 1'h0;
            fr_d_ff <= 1'h0;
            strap_m_ff <= 8'h0;
            strap_s_ff <= 8'h0;
            pin_m_ff <= '1;
            pin_s_ff <= '1;
            ack_m_ff <= 1'h0;
            ack_s_ff <= 1'h0;
            ack_d_ff <= 1'h0;
        end
        else
        begin
            fr_m_ff <= fundamental_reset_n_i;
            fr_s_ff <= fr_m_ff;
            fr_d_ff <= fr_s_ff;
            strap_m_ff <= {master_eeprom_addr_strap_i, slave_addr_strap_i};
            strap_s_ff <= strap_m_ff;
            pin_m_ff <= gpio_pin_i;
            pin_s_ff <= pin_m_ff;
            ack_m_ff <= ack_tgl_w;
            ack_s_ff <= ack_m_ff;
            ack_d_ff <= ack_s_ff;
        end
    end

    // Strap 3:0 = slave pins 5,3,2,1; strap 7:4 = master pins 4..1
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            slave_addr_o <= 7'h0;
            eeprom_addr_o <= 7'h0;
        end
        else if (fr_rise_w)
        begin
            slave_addr_o <= {`HPX_SLV_HI, strap_s_ff[3], `HPX_SLV_B4, strap_s_ff[2:0]};
            eeprom_addr_o <= {`HPX_EE_HI, strap_s_ff[7:4]};
        end
    end

    // Per-pin direction and alternate-function muxing
    genvar gi;
    generate
        for (gi = 0; gi < `HPX_GPIO_NUM; gi++)
        begin : g_pin
            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    oe_ff[gi] <= 1'h0;
                    out_ff[gi] <= 1'h0;
                end
                else
                begin
                    oe_ff[gi] <= alt_en_w[gi] ? alt_oe_i[gi] : gpio_dir_i[gi];
                    out_ff[gi] <= alt_en_w[gi] ? alt_out_i[gi] : gpio_out_i[gi];
                end
            end
        end
    endgenerate
    assign gpio_pin_o = out_ff;
    assign gpio_pin_oe_o = oe_ff;
    assign gpio_in_o = pin_s_ff;

    // Transaction sequencer: EEPROM load, then hot-plug service
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ff <= hpx_pkg::HPX_T_BOOT;
            req_tgl_ff <= 1'h0;
            rd_ff <= 1'h0;
            addr_ff <= 7'h0;
            len_ff <= 4'h0;
            wdata_ff <= 64'h0;
            sent_ff <= '0;
            cfg_done_o <= 1'h0;
            cfg_default_o <= 64'h0;
            hp_in_o <= '0;
            hp_nack_o <= 1'h0;
        end
        else
        begin
            case (st_ff)
                hpx_pkg::HPX_T_BOOT:
                begin
                    if (fr_rise_w)
                    begin
                        st_ff <= hpx_pkg::HPX_T_EE;
                        cfg_done_o <= 1'h0;
                        rd_ff <= `HPX_RD;
                        addr_ff <= {`HPX_EE_HI, strap_s_ff[7:4]};
                        len_ff <= `HPX_EE_BYTES;
                        req_tgl_ff <= ~req_tgl_ff;
                    end
                end
                hpx_pkg::HPX_T_EE:
                begin
                    if (done_w)
                    begin
                        st_ff <= hpx_pkg::HPX_T_IDLE;
                        cfg_default_o <= eng_nack_w ? 64'h0 : rdata_w;
                        cfg_done_o <= 1'h1;
                    end
                end
                hpx_pkg::HPX_T_IDLE:
                begin
                    if (!fr_s_ff)
                        st_ff <= hpx_pkg::HPX_T_BOOT;
                    else if (out_dirty_w)
                    begin
                        st_ff <= hpx_pkg::HPX_T_BUSY;
                        rd_ff <= `HPX_WR;
                        addr_ff <= EXP_ADDR;
                        len_ff <= 4'(HP_OUT_BYTES);
                        wdata_ff <= hp_wdata_w;
                        sent_ff <= hp_out_i;
                        req_tgl_ff <= ~req_tgl_ff;
                    end
                    else if (irq_req_w)
                    begin
                        st_ff <= hpx_pkg::HPX_T_BUSY;
                        rd_ff <= `HPX_RD;
                        addr_ff <= EXP_ADDR;
                        len_ff <= 4'(HP_IN_BYTES);
                        req_tgl_ff <= ~req_tgl_ff;
                    end
                end
                default:
                begin
                    if (done_w)
                    begin
                        st_ff <= hpx_pkg::HPX_T_IDLE;
                        hp_nack_o <= eng_nack_w;
                        if (rd_ff == `HPX_RD && !eng_nack_w)
                            hp_in_o <= rdata_w[IW-1:0];
                    end
                end
            endcase
        end
    end

    hpx_smb_engine u_engine
    (
        .link_clk_i(smb_link_clk_i),
        .rst_b_i(rst_b_i),
        .req_tgl_i(req_tgl_ff),
        .addr_i(addr_ff),
        .rd_i(rd_ff),
        .len_i(len_ff),
        .wdata_i(wdata_ff),
        .ack_tgl_o(ack_tgl_w),
        .rdata_o(rdata_w),
        .nack_o(eng_nack_w),
        .sda_i(msmb_sda_i),
        .scl_oe_o(msmb_scl_oe_o),
        .sda_oe_o(msmb_sda_oe_o)
    );
endmodule

// ===== testbench/hpx_top_monitor.sv
`timescale 1ns/10ps
`include "hpx_map.svh"
module hpx_top_monitor
#(
    parameter int HP_IN_BYTES = 2
)
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic smb_link_clk_i,
    input wire logic fundamental_reset_n_i,
    input wire logic [6:0] slave_addr_o,
    input wire logic [6:0] eeprom_addr_o,
    input wire logic cfg_done_o,
    input wire logic [63:0] cfg_default_o,
    input wire logic [8*HP_IN_BYTES-1:0] hp_in_o,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_dir_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_en_sw_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_en_slave_i,
    input wire logic [`HPX_GPIO_NUM-1:0] alt_oe_i,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_pin_i,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_pin_oe_o,
    input wire logic [`HPX_GPIO_NUM-1:0] gpio_in_o,
    input wire logic msmb_scl_oe_o
);
    wire [`HPX_GPIO_NUM-1:0] alt_on = alt_en_sw_i | alt_en_slave_i | cfg_default_o[53:0];
    wire [`HPX_GPIO_NUM-1:0] oe_want = (alt_on & alt_oe_i) | (~alt_on & gpio_dir_i);
    property p_slv_hi;
        @(posedge core_clk_i) disable iff (!rst_b_i) cfg_done_o |-> slave_addr_o[6:5] == 2'h3;
    endproperty
    a_slv_hi: assert property (p_slv_hi) else $error("slave upper bits wrong");
    property p_ee_hi;
        @(posedge core_clk_i) disable iff (!rst_b_i) $rose(cfg_done_o) |-> eeprom_addr_o[6:4] == 3'h5;
    endproperty
    a_ee_hi: assert property (p_ee_hi) else $error("eeprom upper bits wrong");
    property p_slv_b4;
        @(posedge core_clk_i) disable iff (!rst_b_i) cfg_done_o |-> slave_addr_o[3] == 1'h0;
    endproperty
    a_slv_b4: assert property (p_slv_b4) else $error("slave bit four set");
    property p_strap_hold;
        @(posedge core_clk_i) disable iff (!rst_b_i) fundamental_reset_n_i [*7] ##0 cfg_done_o
            |-> $stable(slave_addr_o) && $stable(eeprom_addr_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("address moved after latch");
    property p_oe_sel;
        @(posedge core_clk_i) disable iff (!rst_b_i) $past(rst_b_i) |-> gpio_pin_oe_o == $past(oe_want);
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("pin enable wrong");
    property p_in_sync;
        @(posedge core_clk_i) disable iff (!rst_b_i) $past(rst_b_i, 2) |-> gpio_in_o == $past(gpio_pin_i, 2);
    endproperty
    a_in_sync: assert property (p_in_sync) else $error("pin input level wrong");
    property p_cfg_first;
        @(posedge core_clk_i) disable iff (!rst_b_i) !cfg_done_o && !$past(cfg_done_o) |-> $stable(hp_in_o);
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("hot-plug read before load");
    property p_scl_high;
        @(posedge smb_link_clk_i) disable iff (!rst_b_i) $fell(msmb_scl_oe_o) |=> !msmb_scl_oe_o;
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
endmodule

// ===== testbench/hpx_exp_model.sv
`timescale 1ns/10ps
`include "hpx_map.svh"
module hpx_exp_model
(
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [6:0] ee_addr_i,
    input wire logic [63:0] ee_data_i,
    input wire logic [15:0] exp_in_i,
    input wire logic irq_hold_i,
    output logic sda_oe_o,
    output logic irq_n_o,
    output logic [15:0] exp_out_o,
    output int n_rd_o,
    output int n_wb_o
);
    logic [7:0] sh;
    logic [63:0] src;
    logic [15:0] tmp;
    int bits, nb;
    logic ack, first, rd, ee, hit, done;
    initial
    begin
        {sda_oe_o, ack, first, rd, ee, hit} = '0;
        {irq_n_o, done} = 2'h3;
        {exp_out_o, tmp, sh, src} = '0;
        {n_rd_o, n_wb_o, bits, nb} = '0;
    end
    always @(exp_in_i or posedge irq_hold_i) irq_n_o = 1'b0;
    always @(negedge sda_i)
        if (scl_i)
        begin
            {first, done, ack} = 3'h4;
            {bits, nb} = '0;
        end
    always @(posedge sda_i)
        if (scl_i && hit && !rd && !ee)
        begin
            exp_out_o = tmp;
            n_wb_o = nb;
        end
    always @(posedge scl_i)
        if (!done && ack && rd)
            done = sda_i;
        else if (!done && !ack)
        begin
            sh = {sh[6:0], sda_i};
            bits++;
        end
    task automatic end_byte;
        bits = 0;
        ack = 1'b1;
        if (first)
        begin
            first = 1'b0;
            rd = sh[0];
            ee = sh[7:1] == ee_addr_i;
            hit = ee || sh[7:1] == `HPX_EXP_ADDR;
            sda_oe_o = hit;
            src = ee ? ee_data_i : {exp_in_i, 48'h0};
            if (hit && rd && !ee)
                n_rd_o++;
            if (hit && rd && !ee && !irq_hold_i)
                irq_n_o = 1'b1;
        end
        else if (rd)
        begin
            sda_oe_o = 1'b0;
            src = src << 8;
        end
        else
        begin
            tmp = {sh, tmp[15:8]};
            nb++;
            sda_oe_o = 1'b1;
        end
    endtask
    // Data changes only while the clock line is low
    always @(negedge scl_i)
        if (done)
            sda_oe_o = 1'b0;
        else if (ack)
        begin
            ack = 1'b0;
            done = !hit;
            sda_oe_o = hit && rd && !src[63];
        end
        else if (bits == 8)
            end_byte();
        else if (rd && !first)
            sda_oe_o = !src[63 - bits];
endmodule

// ===== testbench/hotplug_expander_smbus_master_tb_top.sv
`timescale 1ns/10ps
`include "hpx_map.svh"
module hotplug_expander_smbus_master_tb_top;
    localparam logic [63:0] EE_DATA = 64'h5A3C_0000_0010_0000;
    localparam logic [6:0] EE_ADDR = 7'h56;
    logic core_clk_i = 1'b0;
    logic smb_link_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic fundamental_reset_n_i = 1'b0;
    logic [3:0] slave_addr_strap_i = 4'hA;
    logic [3:0] master_eeprom_addr_strap_i = 4'h6;
    logic [15:0] hp_out_i = 16'h0, exp_in = 16'h0, hp_in_o, exp_out;
    logic [53:0] gpio_dir_i = '0, gpio_out_i = '0, alt_en_sw_i = 54'h100, alt_en_slave_i = '0;
    logic [53:0] alt_out_i = '0, alt_oe_i = '0, pins = '0, gpio_pin_o, gpio_pin_oe_o, gpio_in_o;
    logic [6:0] slave_addr_o, eeprom_addr_o;
    logic [63:0] cfg_default_o;
    logic irq_hold = 1'b0;
    logic cfg_done_o, hp_nack_o, msmb_scl_o, msmb_scl_oe_o, msmb_sda_o, msmb_sda_oe_o, sda_oe_m, irq_n;
    int n_errors = 0, total_checks = 0, cyc = 0, n_rd, n_wb;
    wire scl = !msmb_scl_oe_o;
    wire msmb_sda_i = !(msmb_sda_oe_o || sda_oe_m);
    wire [53:0] gpio_pin_i = {pins[53:9], irq_n, pins[7:0]};
    always #50 core_clk_i = !core_clk_i;
    always #80 smb_link_clk_i = !smb_link_clk_i;
    hpx_top DUT (.core_clk_i, .rst_b_i, .smb_link_clk_i, .fundamental_reset_n_i,
        .slave_addr_strap_i, .master_eeprom_addr_strap_i, .slave_addr_o, .eeprom_addr_o,
        .cfg_done_o, .cfg_default_o, .hp_out_i, .hp_in_o, .hp_nack_o, .gpio_dir_i, .gpio_out_i,
        .alt_en_sw_i, .alt_en_slave_i, .alt_out_i, .alt_oe_i, .gpio_pin_i, .gpio_pin_o,
        .gpio_pin_oe_o, .gpio_in_o, .msmb_sda_i, .msmb_scl_o, .msmb_scl_oe_o, .msmb_sda_o,
        .msmb_sda_oe_o);
    hpx_exp_model u_exp (.scl_i(scl), .sda_i(msmb_sda_i), .ee_addr_i(EE_ADDR), .ee_data_i(EE_DATA),
        .exp_in_i(exp_in), .irq_hold_i(irq_hold), .sda_oe_o(sda_oe_m), .irq_n_o(irq_n),
        .exp_out_o(exp_out), .n_rd_o(n_rd), .n_wb_o(n_wb));
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("FAIL at %0t: saw %0h, wanted %0h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic t_boot;
        int i;
        @(posedge core_clk_i);
        fundamental_reset_n_i <= 1'b1;
        for (i = 0; i < 4000 && cfg_done_o !== 1'b1; i++) @(posedge core_clk_i);
        check(slave_addr_o, {2'h3, slave_addr_strap_i[3], 1'h0, slave_addr_strap_i[2:0]});
        check(eeprom_addr_o, {3'h5, master_eeprom_addr_strap_i});
        check(cfg_default_o, EE_DATA);
        check({msmb_scl_o, msmb_sda_o}, 2'h0);
        slave_addr_strap_i <= 4'h5;
        master_eeprom_addr_strap_i <= 4'h9;
        repeat (20) @(posedge core_clk_i);
        check(slave_addr_o, 7'h72);
        check(eeprom_addr_o, EE_ADDR);
        $display("test boot finished");
    endtask
    task automatic t_write;
        logic [15:0] v [2] = '{16'h00A5, 16'h3CA5};
        int i, k;
        for (k = 0; k < 2; k++)
        begin
            @(posedge core_clk_i);
            hp_out_i <= v[k];
            for (i = 0; i < 4000 && exp_out !== v[k]; i++) @(posedge core_clk_i);
            check(exp_out, v[k]);
            check(n_wb, 2'h2);
        end
        $display("test write finished");
    endtask
    task automatic t_irq;
        int i, r0;
        @(posedge core_clk_i);
        exp_in <= 16'hC381;
        for (i = 0; i < 4000 && hp_in_o !== 16'hC381; i++) @(posedge core_clk_i);
        check(hp_in_o, 16'hC381);
        check(hp_nack_o, 1'h0);
        r0 = n_rd;
        irq_hold <= 1'b1;
        for (i = 0; i < 4000 && n_rd < r0 + 3; i++) @(posedge core_clk_i);
        check(n_rd >= r0 + 3, 1'h1);
        irq_hold <= 1'b0;
        for (i = 0; i < 4000 && irq_n !== 1'b1; i++) @(posedge core_clk_i);
        r0 = n_rd;
        repeat (1000) @(posedge core_clk_i);
        check(n_rd, r0);
        $display("test interrupt finished");
    endtask
    task automatic t_gpio;
        logic [53:0] alt;
        int k;
        for (k = 0; k < 2; k++)
        begin
            @(posedge core_clk_i);
            gpio_dir_i <= 54'h15_5555_AAAA_F0F0 ^ {54{k[0]}};
            gpio_out_i <= 54'h2A_0F0F_3333_CCCC ^ {54{k[0]}};
            alt_out_i <= 54'h3F_0000_FFFF_00FF;
            alt_oe_i <= 54'h00_FFFF_0F0F_00F0;
            alt_en_slave_i <= k ? 54'h00_0000_0000_000F : 54'h0;
            pins <= 54'h12_3456_789A_BCDE ^ {54{k[0]}};
            repeat (4) @(posedge core_clk_i);
            alt = alt_en_sw_i | alt_en_slave_i | EE_DATA[53:0];
            check(gpio_pin_oe_o, (alt & alt_oe_i) | (~alt & gpio_dir_i));
            check(gpio_pin_o, (alt & alt_out_i) | (~alt & gpio_out_i));
            check(gpio_in_o, gpio_pin_i);
        end
        $display("test gpio finished");
    endtask
    task automatic t_reboot;
        int i;
        @(posedge core_clk_i);
        fundamental_reset_n_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        fundamental_reset_n_i <= 1'b1;
        for (i = 0; i < 100 && cfg_done_o !== 1'b0; i++) @(posedge core_clk_i);
        for (i = 0; i < 4000 && cfg_done_o !== 1'b1; i++) @(posedge core_clk_i);
        check(slave_addr_o, 7'h65);
        check(eeprom_addr_o, 7'h59);
        check(cfg_default_o, 64'h0);
        $display("test reboot finished");
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_boot();
        t_write();
        t_irq();
        t_gpio();
        t_reboot();
        report_and_stop();
    end
endmodule
bind hpx_top hpx_top_monitor #(.HP_IN_BYTES(HP_IN_BYTES)) u_mon (.core_clk_i, .rst_b_i,
    .smb_link_clk_i, .fundamental_reset_n_i, .slave_addr_o, .eeprom_addr_o, .cfg_done_o,
    .cfg_default_o, .hp_in_o, .gpio_dir_i, .alt_en_sw_i, .alt_en_slave_i, .alt_oe_i,
    .gpio_pin_i, .gpio_pin_oe_o, .gpio_in_o, .msmb_scl_oe_o);
